// ---- hw/comm_status_params.svh ----
// Constants for the communications unit status block: register offsets,
// field positions, reset values, codes and timing figures.
// Assumes it is included once per compilation unit by its bare name.
`ifndef COMM_STATUS_PARAMS_SVH
`define COMM_STATUS_PARAMS_SVH

// Register offsets on the plain register port
`define ADDR_CONTROL      4'h0
`define ADDR_STATUS       4'h1
`define ADDR_SYNTAX_LOC   4'h2
`define ADDR_TYPE_WR      4'h3
`define ADDR_IRQ_STATUS   4'h8
`define ADDR_IRQ_CLEAR    4'h9
`define ADDR_IRQ_ENABLE   4'hA

// Field positions and reset values
`define TYPE_IDX_LSB      8
`define CONTROL_RESET     16'h0000
`define SYNTAX_LOC_RESET  16'h0000
`define IRQ_ENABLE_RESET  4'h0

// Digit and code values of the status word
`define RUN_ON            4'h1
`define RUN_OFF           4'h0
`define ERR_ON            4'h8
`define ERR_OFF           4'h0
`define UNIT_NONE_BCD     8'h00
`define CODE_WATCHDOG     8'h01
`define CODE_SYNTAX       8'h02
`define CODE_ALLOC        8'h15
`define TYPE_NONE         8'h00

// Interrupt status bit positions
`define IRQ_UNIT          0
`define IRQ_SYNTAX        1
`define IRQ_FATAL         2
`define IRQ_HALT          3
`define IRQ_WIDTH         4

// Timing
`define CLK_PERIOD_NS     100
`define ERR_BLINK_MS      500
`define ERR_BLINK_CYCLES  (`ERR_BLINK_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ---- hw/comm_status_pkg.sv ----
// Types shared by the communications unit status block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package comm_status_pkg;

   typedef struct packed {
      logic [3:0] error_digit;
      logic [3:0] run_digit;
      logic [7:0] low_byte;
   } status_word_t;

   typedef struct packed {
      logic [7:0] unit_count;
      logic [3:0] timeout_digit;
      logic [3:0] run_digit;
   } control_word_t;

   typedef struct packed {
      logic       strobe;
      logic [4:0] unit;
   } unit_event_t;

   typedef struct packed {
      logic        strobe;
      logic [15:0] location;
   } syntax_event_t;

   typedef enum logic [0:0] {
      RPT_IDLE = 1'b0,
      RPT_WAIT = 1'b1
   } rpt_state_t;

endpackage

`default_nettype wire

// ---- hw/unit_bcd.sv ----
// Converts a unit number 0..31 to two BCD digits.
// Assumes the input never exceeds 31; purely combinational.
`default_nettype none

module unit_bcd
(
   // Binary unit number
   input  wire logic [4:0] unit_bin,
   // Two BCD digits
   output logic      [7:0] unit_bcd_out
);

   logic [3:0] tens;
   logic [4:0] ones;

   always_comb
   begin
      if (unit_bin >= 5'h1E)
      begin
         tens = 4'h3;
         ones = unit_bin - 5'h1E;
      end
      else if (unit_bin >= 5'h14)
      begin
         tens = 4'h2;
         ones = unit_bin - 5'h14;
      end
      else if (unit_bin >= 5'h0A)
      begin
         tens = 4'h1;
         ones = unit_bin - 5'h0A;
      end
      else
      begin
         tens = 4'h0;
         ones = unit_bin;
      end
   end

   assign unit_bcd_out = {tens, ones[3:0]};

endmodule // unit_bcd

`default_nettype wire

// ---- hw/unit_type_mem.sv ----
// Per-unit communications type table, 32 entries of 8 bits.
// Assumes one write and one read port; read data come from a register.
`default_nettype none

module unit_type_mem
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [4:0] wr_idx,
   input  wire logic [7:0] wr_data,
   // Read port
   input  wire logic [4:0] rd_idx,
   output logic      [7:0] rd_data
);

   logic [7:0] entry_reg [32];

   // Cleared at reset so that every unit starts as not connected
   for (genvar i = 0; i < 32; i++)
   begin : g_entry
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
            entry_reg[i] <= 8'h00;
         else if (wr_en && (wr_idx == 5'(i)))
            entry_reg[i] <= wr_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= 8'h00;
      else
         rd_data <= entry_reg[rd_idx];
   end

endmodule // unit_type_mem

`default_nettype wire

// ---- hw/comm_status.sv ----
// Status reporting of the serial communications unit: status word, syntax
// error location, halt on unreportable faults, error indicator, interrupt.
// Assumes all inputs are synchronous to clock; event inputs are one-cycle pulses.
//
// Design decision made here: the strobed register port.
`include "comm_status_params.svh"
`default_nettype none

// Summary of operation
// - With no fatal error, the status low byte shows the BCD number 00 to 31 of the last unit done.
// - The shown unit number changes only after the host has taken that unit's read data.
// - From reset until a unit completes, the unit number field reads 00.
// - The field reads 00 when the unit count is 00, run is off, or that unit is not connected.
// - Bits 8 to 11 of the status word read 1 while running and 0 while stopped, but keep their last value once a halt freezes the word.
// - Bits 12 to 15 read 0 while no fatal error has occurred.
// - Host data memory locked in run, a failed host link, or protected program memory are unreportable.
// - Any unreportable fault halts all communications and lights the error indicator steadily.
// - A syntax error stores its BCD host data memory location in the syntax location word.
// - Only the first syntax error location is kept; later ones never overwrite it.
// - With bit 15 set, the low byte carries code 01 watchdog or 15 allocation.
module comm_status
   import comm_status_pkg::*;
#(
   parameter int BLINK_CYCLES = `ERR_BLINK_CYCLES
)
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          nrst,
   // Register port
   input  wire logic [3:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [15:0]   reg_rdata,
   // Polling engine events
   input  wire unit_event_t   unit_read_done,
   input  wire logic          host_xfer_done,
   input  wire syntax_event_t syntax_err,
   input  wire logic          watchdog_err,
   input  wire logic          alloc_err,
   // Host side fault levels
   input  wire logic          host_dm_locked,
   input  wire logic          host_link_fail,
   input  wire logic          host_prog_protected,
   // Unit outputs
   output logic               comms_enable,
   output logic               err_led,
   output logic               irq
);

   logic                   rst_meta_reg;
   logic                   rst_n;
   control_word_t          control_reg;
   status_word_t           status_reg;
   status_word_t           status_next;
   logic [15:0]            syntax_loc_reg;
   logic                   syntax_seen_reg;
   logic                   fatal_reg;
   logic [7:0]             fatal_code_reg;
   logic                   halt_reg;
   logic                   running_reg;
   logic                   running_next;
   rpt_state_t             state_reg;
   logic [4:0]             pend_unit_reg;
   logic [4:0]             last_unit_reg;
   logic                   last_valid_reg;
   logic [4:0]             type_rd_idx;
   logic [7:0]             type_rdata;
   logic [7:0]             last_unit_bcd;
   logic [`IRQ_WIDTH-1:0]  irq_status_reg;
   logic [`IRQ_WIDTH-1:0]  irq_enable_reg;
   logic [`IRQ_WIDTH-1:0]  irq_events;
   logic [31:0]            blink_cnt_reg;
   logic                   blink_tick;
   logic                   blink_reg;
   logic                   unreportable;
   logic                   report_done;
   logic                   type_wr;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   assign type_wr      = reg_wr && (reg_addr == `ADDR_TYPE_WR);
   assign unreportable = host_dm_locked || host_link_fail || host_prog_protected;
   assign report_done  = (state_reg == RPT_WAIT) && host_xfer_done;

   // Control word written by software steers the run state
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         control_reg <= control_word_t'(`CONTROL_RESET);
      else if (reg_wr && (reg_addr == `ADDR_CONTROL))
         control_reg <= control_word_t'(reg_wdata);
   end

   // Type lookup follows the unit about to become the reported one
   assign type_rd_idx = report_done ? pend_unit_reg : last_unit_reg;

   unit_type_mem u_type_mem
   (
      .clock   (clock),
      .rst_n   (rst_n),
      .wr_en   (type_wr),
      .wr_idx  (reg_wdata[`TYPE_IDX_LSB +: 5]),
      .wr_data (reg_wdata[7:0]),
      .rd_idx  (type_rd_idx),
      .rd_data (type_rdata)
   );

   unit_bcd u_unit_bcd
   (
      .unit_bin     (last_unit_reg),
      .unit_bcd_out (last_unit_bcd)
   );

   // Halting on a fault the host cannot be told about is permanent until reset
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         halt_reg <= 1'b0;
      else if (unreportable)
         halt_reg <= 1'b1;
   end

   // First fatal error wins; watchdog outranks allocation in the same cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fatal_reg      <= 1'b0;
         fatal_code_reg <= 8'h00;
      end
      else if (!fatal_reg && watchdog_err)
      begin
         fatal_reg      <= 1'b1;
         fatal_code_reg <= `CODE_WATCHDOG;
      end
      else if (!fatal_reg && alloc_err)
      begin
         fatal_reg      <= 1'b1;
         fatal_code_reg <= `CODE_ALLOC;
      end
   end

   // Syntax location is captured once and then frozen
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syntax_seen_reg <= 1'b0;
         syntax_loc_reg  <= `SYNTAX_LOC_RESET;
      end
      else if (syntax_err.strobe && !syntax_seen_reg)
      begin
         syntax_seen_reg <= 1'b1;
         syntax_loc_reg  <= syntax_err.location;
      end
   end

   // A syntax error stops polling but is not fatal
   assign running_next = (control_reg.run_digit == `RUN_ON) && (control_reg.unit_count != 8'h00)
                         && !fatal_reg && !syntax_seen_reg && !halt_reg && !unreportable;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         running_reg <= 1'b0;
      else
         running_reg <= running_next;
   end

   // Unit number moves only once the host has the unit's data
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg      <= RPT_IDLE;
         pend_unit_reg  <= 5'h00;
         last_unit_reg  <= 5'h00;
         last_valid_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            RPT_IDLE:
            begin
               if (unit_read_done.strobe && running_reg)
               begin
                  pend_unit_reg <= unit_read_done.unit;
                  state_reg     <= RPT_WAIT;
               end
            end
            RPT_WAIT:
            begin
               if (host_xfer_done)
               begin
                  last_unit_reg  <= pend_unit_reg;
                  last_valid_reg <= 1'b1;
                  state_reg      <= RPT_IDLE;
               end
               if (unit_read_done.strobe && running_reg)
               begin
                  pend_unit_reg <= unit_read_done.unit;
                  state_reg     <= RPT_WAIT;
               end
            end
            default:
               state_reg <= RPT_IDLE;
         endcase
      end
   end

   // Status word layout depends on whether a fatal error is flagged
   always_comb
   begin
      status_next.run_digit = running_reg ? `RUN_ON : `RUN_OFF;
      if (fatal_reg)
      begin
         status_next.error_digit = `ERR_ON;
         status_next.low_byte    = fatal_code_reg;
      end
      else
      begin
         status_next.error_digit = `ERR_OFF;
         if (!last_valid_reg || (control_reg.unit_count == 8'h00)
             || (control_reg.run_digit != `RUN_ON) || (type_rdata == `TYPE_NONE))
            status_next.low_byte = `UNIT_NONE_BCD;
         else
            status_next.low_byte = last_unit_bcd;
      end
   end

   // Once halted the host can no longer be updated, so the word freezes
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         status_reg <= status_word_t'(16'h0000);
      else if (!halt_reg)
         status_reg <= status_next;
   end

   // Slow enable for a flashing indicator on a non-fatal syntax error
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         blink_cnt_reg <= 32'h00000000;
      else if (blink_tick)
         blink_cnt_reg <= 32'h00000000;
      else
         blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
   end

   assign blink_tick = (blink_cnt_reg == 32'(BLINK_CYCLES - 1));

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         blink_reg <= 1'b0;
      else if (blink_tick)
         blink_reg <= !blink_reg;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         err_led <= 1'b0;
      else
         err_led <= halt_reg || unreportable || fatal_reg || (syntax_seen_reg && blink_reg);
   end

   assign comms_enable = running_reg;

   // Sticky interrupt sources; a new event wins over a clear in the same cycle
   assign irq_events[`IRQ_UNIT]   = report_done;
   assign irq_events[`IRQ_SYNTAX] = syntax_err.strobe && !syntax_seen_reg;
   assign irq_events[`IRQ_FATAL]  = !fatal_reg && (watchdog_err || alloc_err);
   assign irq_events[`IRQ_HALT]   = !halt_reg && unreportable;

   for (genvar b = 0; b < `IRQ_WIDTH; b++)
   begin : g_irq
      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
            irq_status_reg[b] <= 1'b0;
         else if (irq_events[b])
            irq_status_reg[b] <= 1'b1;
         else if (reg_wr && (reg_addr == `ADDR_IRQ_CLEAR) && reg_wdata[b])
            irq_status_reg[b] <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         irq_enable_reg <= `IRQ_ENABLE_RESET;
      else if (reg_wr && (reg_addr == `ADDR_IRQ_ENABLE))
         irq_enable_reg <= reg_wdata[`IRQ_WIDTH-1:0];
   end

   assign irq = |(irq_status_reg & irq_enable_reg);

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (!reg_rd)
         reg_rdata <= 16'h0000;
      else
      begin
         case (reg_addr)
            `ADDR_CONTROL:    reg_rdata <= control_reg;
            `ADDR_STATUS:     reg_rdata <= status_reg;
            `ADDR_SYNTAX_LOC: reg_rdata <= syntax_loc_reg;
            `ADDR_IRQ_STATUS: reg_rdata <= {12'h000, irq_status_reg};
            `ADDR_IRQ_ENABLE: reg_rdata <= {12'h000, irq_enable_reg};
            default:          reg_rdata <= 16'h0000;
         endcase
      end
   end

   // Checks on the reported state
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence host_ack_s;
      (state_reg == RPT_WAIT) && host_xfer_done;
   endsequence

   sequence unit_moved_s;
      ##1 (last_unit_reg == $past(pend_unit_reg)) && last_valid_reg;
   endsequence

   property unit_after_ack_p;
      host_ack_s |-> unit_moved_s;
   endproperty

   unit_after_ack_a: assert property (unit_after_ack_p)
      else $error("reported unit did not follow the host transfer");

   unit_stable_a: assert property (!$past(report_done) |-> $stable(last_unit_reg))
      else $error("reported unit changed without a host transfer");

   unit_range_a: assert property ((!fatal_reg && !halt_reg && last_valid_reg
                                   && type_rdata != `TYPE_NONE
                                   && control_reg.run_digit == `RUN_ON
                                   && control_reg.unit_count != 8'h00)
                                  |=> status_reg.low_byte == $past(last_unit_bcd))
      else $error("status low byte does not show the last unit");

   power_up_zero_a: assert property ((!last_valid_reg && !fatal_reg && !halt_reg)
                                     |=> status_reg.low_byte == `UNIT_NONE_BCD)
      else $error("unit field not 00 before any unit completed");

   idle_zero_a: assert property ((!fatal_reg && !halt_reg
                                  && (control_reg.unit_count == 8'h00
                                      || control_reg.run_digit != `RUN_ON))
                                 |=> status_reg.low_byte == `UNIT_NONE_BCD)
      else $error("unit field not 00 with no units or run off");

   run_digit_a: assert property (!halt_reg |=>
                                 status_reg.run_digit == {3'b000, $past(running_reg)})
      else $error("run digit does not match the run state");

   no_fatal_digit_a: assert property ((!fatal_reg && !halt_reg)
                                      |=> status_reg.error_digit == `ERR_OFF)
      else $error("error digit set without a fatal error");

   halt_entry_a: assert property (unreportable |=> halt_reg && !comms_enable)
      else $error("unreportable fault did not halt the unit");

   halt_led_a: assert property (halt_reg |=> err_led && !comms_enable [*2])
      else $error("halted unit not steady lit or still polling");

   syntax_store_a: assert property ((syntax_err.strobe && !syntax_seen_reg)
                                    |=> syntax_loc_reg == $past(syntax_err.location))
      else $error("syntax location not captured");

   syntax_first_a: assert property (syntax_seen_reg |=> $stable(syntax_loc_reg))
      else $error("syntax location overwritten");

   error_code_a: assert property ((fatal_reg && !halt_reg)
                                  |=> status_reg.error_digit == `ERR_ON
                                      && status_reg.low_byte == $past(fatal_code_reg))
      else $error("fatal status word lacks flag or code");

endmodule // comm_status

`default_nettype wire

// ---- dv/host_engine_model.sv ----
// Stand-in for the polling engine and host transfer path of the block.
// Assumes go is a one-cycle pulse driven right after a rising edge.
`default_nettype none

module host_engine_model
   import comm_status_pkg::*;
(
   // Clock
   input  wire logic       clock,
   // Request from the bench
   input  wire logic       go,
   input  wire logic [4:0] unit,
   input  wire logic [3:0] gap,
   // Engine events toward the block
   output var unit_event_t unit_read_done,
   output logic            host_xfer_done,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      unit_read_done = '0;
      host_xfer_done = 1'b0;
      busy           = 1'b0;
      forever
      begin
         @(posedge clock);
         if (go)
         begin
            busy           <= 1'b1;
            unit_read_done <= '{strobe: 1'b1, unit: unit};
            @(posedge clock);
            // Released field changes so a stale unit number cannot pass
            unit_read_done <= '{strobe: 1'b0, unit: ~unit};
            repeat (gap) @(posedge clock);
            host_xfer_done <= 1'b1;
            @(posedge clock);
            host_xfer_done <= 1'b0;
            busy           <= 1'b0;
         end
      end
   end

endmodule // host_engine_model

`default_nettype wire

// ---- dv/comm_status_bench.sv ----
// Self-checking bench for the status reporting block.
// Assumes the design files and host_engine_model are compiled first.
`include "comm_status_params.svh"
`default_nettype none

module comm_status_bench
   import comm_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic          clock;
   logic          nrst;
   logic [3:0]    reg_addr;
   logic [15:0]   reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [15:0]   reg_rdata;
   unit_event_t   unit_read_done;
   logic          host_xfer_done;
   syntax_event_t syntax_err;
   logic          watchdog_err;
   logic          alloc_err;
   logic [2:0]    fault;
   logic          comms_enable;
   logic          err_led;
   logic          irq;
   logic          go;
   logic [4:0]    unit_sel;
   logic [3:0]    gap_sel;
   logic          busy;
   logic [15:0]   d;
   int            n_mismatch;
   int            n_checks;

   comm_status #(.BLINK_CYCLES(4)) comm_status_i (
      .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .unit_read_done(unit_read_done), .host_xfer_done(host_xfer_done),
      .syntax_err(syntax_err), .watchdog_err(watchdog_err), .alloc_err(alloc_err),
      .host_dm_locked(fault[0]), .host_link_fail(fault[1]),
      .host_prog_protected(fault[2]), .comms_enable(comms_enable),
      .err_led(err_led), .irq(irq));

   host_engine_model host_engine_model_i (
      .clock(clock), .go(go), .unit(unit_sel), .gap(gap_sel),
      .unit_read_done(unit_read_done), .host_xfer_done(host_xfer_done), .busy(busy));

   always #50 clock = ~clock;

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
      rd(a);
      check(name, d, exp);
   endtask

   task automatic pin_chk(input string name, input logic seen, input logic exp);
      check(name, {15'h0000, seen}, {15'h0000, exp});
   endtask

   task automatic start_report(input logic [4:0] u, input logic [3:0] g);
      @(posedge clock);
      go       <= 1'b1;
      unit_sel <= u;
      gap_sel  <= g;
      @(posedge clock);
      go       <= 1'b0;
   endtask

   // Bounded wait so a stuck handshake cannot hang the run
   task automatic finish_report();
      int k;
      k = 0;
      #1;
      while (busy !== 1'b0 && k < 40)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      check("engine idle", 16'(k < 40), 16'h0001);
      repeat (2) @(posedge clock);
   endtask

   task automatic do_reset();
      @(posedge clock);
      fault <= 3'b000;
      nrst  <= 1'b0;
      repeat (16) @(posedge clock);
      nrst  <= 1'b1;
      repeat (3) @(posedge clock);
   endtask

   task automatic hold_chk();
      repeat (12)
      begin
         @(posedge clock);
         #1;
         pin_chk("err_led steady", err_led, 1'b1);
      end
   endtask

   initial
   begin
      clock = 1'b0;
      nrst = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      syntax_err = '0;
      watchdog_err = 1'b0;
      alloc_err = 1'b0;
      fault = 3'b000;
      go = 1'b0;
      unit_sel = 5'h00;
      gap_sel = 4'h0;
      n_mismatch = 0;
      n_checks = 0;
      do_reset();
      rd_chk("status at reset", `ADDR_STATUS, 16'h0000);
      rd_chk("syntax location at reset", `ADDR_SYNTAX_LOC, `SYNTAX_LOC_RESET);
      rd_chk("unmapped read", 4'h5, 16'h0000);
      $display("test reset done");

      wr(`ADDR_TYPE_WR, 16'h0C01);
      wr(`ADDR_TYPE_WR, 16'h1F02);
      wr(`ADDR_TYPE_WR, 16'h0500);
      wr(`ADDR_IRQ_ENABLE, 16'h0001);
      wr(`ADDR_CONTROL, 16'h3201);
      // Status trails a control write by two cycles: run state, then status word
      repeat (2) @(posedge clock);
      rd_chk("status running", `ADDR_STATUS, 16'h0100);
      pin_chk("comms_enable running", comms_enable, 1'b1);
      start_report(5'd12, 4'd0);
      finish_report();
      rd_chk("status unit 12", `ADDR_STATUS, 16'h0112);
      pin_chk("irq raised", irq, 1'b1);
      rd_chk("irq status", `ADDR_IRQ_STATUS, 16'h0001);
      wr(`ADDR_IRQ_CLEAR, 16'h0001);
      @(posedge clock);
      #1;
      pin_chk("irq cleared", irq, 1'b0);
      start_report(5'd31, 4'd8);
      repeat (3) @(posedge clock);
      rd_chk("status before transfer", `ADDR_STATUS, 16'h0112);
      finish_report();
      rd_chk("status unit 31", `ADDR_STATUS, 16'h0131);
      $display("test report done");

      wr(`ADDR_CONTROL, 16'h3200);
      repeat (2) @(posedge clock);
      rd_chk("status stopped", `ADDR_STATUS, 16'h0000);
      pin_chk("comms_enable stopped", comms_enable, 1'b0);
      wr(`ADDR_CONTROL, 16'h0001);
      rd(`ADDR_STATUS);
      check("unit field count zero", {8'h00, d[7:0]}, 16'h0000);
      wr(`ADDR_CONTROL, 16'h3201);
      start_report(5'd5, 4'd1);
      finish_report();
      rd_chk("status unit not connected", `ADDR_STATUS, 16'h0100);
      $display("test unit none done");

      @(posedge clock);
      syntax_err <= '{strobe: 1'b1, location: 16'h1234};
      @(posedge clock);
      syntax_err <= '{strobe: 1'b1, location: 16'h5678};
      @(posedge clock);
      syntax_err <= '{strobe: 1'b0, location: 16'hA987};
      rd_chk("first syntax location", `ADDR_SYNTAX_LOC, 16'h1234);
      wr(`ADDR_SYNTAX_LOC, 16'hFFFF);
      rd_chk("syntax location read only", `ADDR_SYNTAX_LOC, 16'h1234);
      rd(`ADDR_STATUS);
      check("error digit after syntax", {12'h000, d[15:12]}, 16'h0000);
      pin_chk("comms_enable after syntax", comms_enable, 1'b0);
      rd(`ADDR_IRQ_STATUS);
      check("irq syntax bit", {15'h0000, d[`IRQ_SYNTAX]}, 16'h0001);
      $display("test syntax done");

      for (int i = 0; i < 2; i++)
      begin
         do_reset();
         wr(`ADDR_CONTROL, 16'h3201);
         @(posedge clock);
         watchdog_err <= (i == 0);
         alloc_err    <= (i == 1);
         @(posedge clock);
         watchdog_err <= 1'b0;
         alloc_err    <= 1'b0;
         repeat (3) @(posedge clock);
         rd_chk("fatal status", `ADDR_STATUS, (i == 0) ? 16'h8001 : 16'h8015);
         pin_chk("comms_enable fatal", comms_enable, 1'b0);
         pin_chk("err_led fatal", err_led, 1'b1);
         rd_chk("irq status fatal", `ADDR_IRQ_STATUS, 16'h0004);
      end
      $display("test fatal done");

      for (int i = 0; i < 3; i++)
      begin
         do_reset();
         wr(`ADDR_CONTROL, 16'h3201);
         @(posedge clock);
         fault <= 3'b001 << i;
         repeat (2) @(posedge clock);
         #1;
         pin_chk("comms_enable halted", comms_enable, 1'b0);
         hold_chk();
         @(posedge clock);
         watchdog_err <= 1'b1;
         @(posedge clock);
         watchdog_err <= 1'b0;
         repeat (3) @(posedge clock);
         rd_chk("status unreportable", `ADDR_STATUS, 16'h0100);
         rd(`ADDR_IRQ_STATUS);
         check("irq halt bit", {15'h0000, d[`IRQ_HALT]}, 16'h0001);
      end
      $display("test unreportable done");
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      $display("MISMATCH run time expected end seen limit");
      test_done();
   end

endmodule // comm_status_bench

`default_nettype wire
